// ==== serial_flash_reset_status_battery_tb.sv ====
`timescale 1ns/1ps
module serial_flash_reset_status_battery_tb;
  import sfrsb_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  localparam int SHORT = 1000;
  localparam int LONG = 2000;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic below = 1'b0;
  logic done = 1'b0;
  logic nvb = 1'b0;
  logic mio = 1'b0;
  logic cs_n, sck, si, so, oe, busy, st, dres, bund, sgl, ldn, b, r;
  // released so shows the inverse of its last level, so a late enable corrupts data
  wire so_pin = oe ? so : ~so;
  logic [2:0] pwr, lvl;
  logic [1:0] ld;
  logic [7:0] sr6, v;
  logic [63:0] q;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int nres = 0;
  int nund = 0;
  int nst = 0;
  int ldlen = 0;
  int l0, c;
  always #2.5 i_sys_clk = ~i_sys_clk;
  sfrsb_top #(.BATT_SHORT_CNT(SHORT), .BATT_LONG_CNT(LONG), .DEVICE_ID(ID)) dut_u (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_spi_cs_n(cs_n), .i_spi_sck(sck), .i_spi_si(si),
    .i_batt_below(below), .i_array_done(done), .i_nv_write_busy(nvb), .i_multi_io_enter(mio),
    .o_spi_so(so), .o_spi_so_oe(oe), .o_op_in_progress_flag(busy), .o_array_start(st), .o_dev_reset(dres),
    .o_buffer_undefined(bund), .o_single_io_mode(sgl), .o_power_state(pwr),
    .o_battery_check_config_status(sr6), .o_battery_threshold_level(lvl), .o_battery_test_load(ld),
    .o_battery_test_load_en(ldn));
  sfrsb_spi_host m_u (.i_clk(i_sys_clk), .i_so(so_pin), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  always @(posedge i_sys_clk) begin
    cyc++;
    nres += int'(dres === 1'b1);
    nund += int'(bund === 1'b1);
    nst += int'(st === 1'b1);
    ldlen += int'(ldn === 1'b1);
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sx(input logic [63:0] d, input int n);
    m_u.xfer(d, n, 1'b0, q);
  endtask
  task automatic wr6(input logic [7:0] d, input int n);
    sx({39'h0, OP_WRITE_SR, SR6_ADDR, d, 1'b0} >> (25 - n), n);
  endtask
  task automatic rd6(input logic [7:0] e);
    sx({40'h0, OP_READ_SR, SR6_ADDR, 8'h00}, 24);
    chk(q[7:0], e);
  endtask
  // status mode: so must fall once the running job ends
  task automatic stat(input bit pulse);
    m_u.xfer({56'h0, OP_ACTIVE_STATUS}, 8, 1'b1, q);
    chk(so_pin, 1);
    if (pulse) begin
      @(posedge i_sys_clk) done <= 1'b1;
      @(posedge i_sys_clk) done <= 1'b0;
    end
    for (int i = 0; i < 4000 && so_pin !== 1'b0; i++) @(posedge i_sys_clk);
    chk(so_pin, 0);
    m_u.release_cs();
  endtask
  task automatic jpat(input logic [7:0] p, input int n, input bit g);
    for (int i = n - 1; i >= 0; i--) m_u.jstep(p[i], g && i == 0);
    m_u.tick(8);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(97));
    repeat (20) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    m_u.tick(10);
    rd6(8'h00);
    repeat (4) begin
      v = 8'($urandom);
      wr6(v, 24);
      rd6({2'b00, v[5:0]});
      chk(lvl, v[5:3]);
      chk(ld, v[2:1]);
    end
    wr6(~v, 25);
    rd6({2'b00, v[5:0]});
    sx({24'h0, OP_PROGRAM, 32'($urandom)} >> 1, 39);
    chk(busy, 0);
    sx({24'h0, OP_PROGRAM, 32'($urandom)}, 40);
    chk(busy, 1);
    chk(8'(nst), 1);
    sx({48'h0, OP_READ_SR1, 8'h00}, 16);
    chk(q[7:0], 8'h01);
    sx({40'h0, OP_READ_SR, SR1_ADDR, 8'h00}, 24);
    chk(q[7:0], 8'h01);
    stat(1'b1);
    chk(busy, 0);
    r = 1'($urandom);
    for (int k = 0; k < 2; k++) begin
      v = {2'b00, 5'($urandom), k[0]};
      b = r ^ k[0];
      below <= b;
      wr6(v, 24);
      l0 = ldlen;
      c = k ? LONG : SHORT;
      sx({56'h0, OP_BATT_CHECK}, 8);
      rd6({RESULT_RUNNING, v[5:0]});
      stat(1'b0);
      chk(8'(ldlen - l0 >= c && ldlen - l0 <= c + 16), 1);
      rd6({b ? RESULT_BELOW : RESULT_ABOVE, v[5:0]});
      sx({56'h0, OP_TERMINATE}, 8);
      rd6({RESULT_IDLE, v[5:0]});
    end
    sx({56'h0, OP_DEEP_PD}, 8);
    chk(pwr, PWR_DEEP);
    sx({55'h0, OP_RELEASE_PD, 1'b0}, 9);
    chk(pwr, PWR_DEEP);
    sx({56'h0, OP_RELEASE_PD}, 8);
    chk(pwr, PWR_ACTIVE);
    sx({56'h0, OP_DEEPEST_PD}, 8);
    sx({23'h0, OP_RELEASE_PD, 33'h0}, 41);
    chk(q[8:1], ID);
    chk(pwr, PWR_DEEPEST);
    sx({24'h0, OP_RELEASE_PD, 32'h0}, 40);
    chk(q[7:0], ID);
    chk(pwr, PWR_ACTIVE);
    wr6(8'h2d, 24);
    sx({56'h0, OP_DEEPEST_PD}, 8);
    @(posedge i_sys_clk) mio <= 1'b1;
    @(posedge i_sys_clk) mio <= 1'b0;
    m_u.tick(4);
    chk(sgl, 0);
    jpat(8'h05, 4, 1'b1);
    chk(8'(nres), 0);
    jpat(8'h25, 7, 1'b0);
    chk(8'(nres), 1);
    chk(8'(nund), 1);
    chk(pwr, PWR_ACTIVE);
    chk(sgl, 1);
    rd6(8'h00);
    nvb <= 1'b1;
    jpat(8'h05, 4, 1'b0);
    m_u.tick(40);
    chk(8'(nres), 1);
    nvb <= 1'b0;
    m_u.tick(20);
    chk(8'(nres), 2);
    chk(8'(nund), 1);
    // power-on reset in mid-run must clear the volatile config again
    wr6(8'h1b, 24);
    i_reset_n <= 1'b0;
    m_u.tick(4);
    i_reset_n <= 1'b1;
    m_u.tick(4);
    rd6(8'h00);
    chk(pwr, PWR_ACTIVE);
    tally_and_finish();
  end
endmodule

// ==== sfrsb_assertions.sv ====
`timescale 1ns/1ps
module sfrsb_assertions
  import sfrsb_pkg::*;
#(
  parameter int unsigned BATT_LONG_CNT = 50
) (
  input wire logic       i_sys_clk,
  input wire logic       i_reset_n,
  input wire logic       i_spi_cs_n,
  input wire logic       i_nv_write_busy,
  input wire logic       o_spi_so_oe,
  input wire logic       o_op_in_progress_flag,
  input wire logic       o_array_start,
  input wire logic       o_dev_reset,
  input wire logic       o_buffer_undefined,
  input wire logic       o_single_io_mode,
  input wire logic [2:0] o_power_state,
  input wire logic [7:0] o_battery_check_config_status,
  input wire logic       o_battery_test_load_en
);
  int unsigned run_cnt;
  wire logic [1:0] res = o_battery_check_config_status[RESULT_MSB:RESULT_LSB];
  default clocking dcb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // counter, since the long duration is far beyond a repetition count
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= o_battery_test_load_en ? run_cnt + 1 : 0;
    end
  end
  property p_busy_on_start;
    o_array_start |=> o_op_in_progress_flag;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy not set");
  property p_run_code;
    o_battery_test_load_en && $past(o_battery_test_load_en) |-> res == RESULT_RUNNING;
  endproperty
  a_run_code: assert property (p_run_code) else $error("result not running");
  property p_done_code;
    $fell(o_battery_test_load_en) |-> res != RESULT_RUNNING;
  endproperty
  a_done_code: assert property (p_done_code) else $error("result stuck running");
  property p_reset_dflt;
    o_dev_reset |-> o_battery_check_config_status == 8'h00 && !o_op_in_progress_flag
      && o_power_state == PWR_ACTIVE && o_single_io_mode;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("state after reset");
  property p_undef;
    o_buffer_undefined |-> o_dev_reset;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined pulse alone");
  property p_hold;
    i_nv_write_busy [*4] |-> !o_dev_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("reset during nv write");
  property p_so_rel;
    i_spi_cs_n [*8] |-> !o_spi_so_oe;
  endproperty
  a_so_rel: assert property (p_so_rel) else $error("so driven while deselected");
  property p_load_time;
    run_cnt <= BATT_LONG_CNT + 8;
  endproperty
  a_load_time: assert property (p_load_time) else $error("load held too long");
endmodule
bind sfrsb_top sfrsb_assertions #(.BATT_LONG_CNT(BATT_LONG_CNT)) chk_u (
  .i_sys_clk, .i_reset_n, .i_spi_cs_n, .i_nv_write_busy, .o_spi_so_oe, .o_op_in_progress_flag,
  .o_array_start, .o_dev_reset, .o_buffer_undefined, .o_single_io_mode, .o_power_state,
  .o_battery_check_config_status, .o_battery_test_load_en
);

// ==== sfrsb_pkg.sv ====
package sfrsb_pkg;
  // opcodes
  localparam logic [7:0] OP_PROGRAM       = 8'h02;
  localparam logic [7:0] OP_READ_SR1      = 8'h05;
  localparam logic [7:0] OP_ACTIVE_STATUS = 8'h25;
  localparam logic [7:0] OP_READ_SR       = 8'h65;
  localparam logic [7:0] OP_WRITE_SR      = 8'h71;
  localparam logic [7:0] OP_DEEPEST_PD    = 8'h79;
  localparam logic [7:0] OP_RELEASE_PD    = 8'hab;
  localparam logic [7:0] OP_DEEP_PD       = 8'hb9;
  localparam logic [7:0] OP_BATT_CHECK    = 8'hef;
  localparam logic [7:0] OP_TERMINATE     = 8'hf0;
  // indirect status register addresses
  localparam logic [7:0] SR1_ADDR = 8'h01;
  localparam logic [7:0] SR6_ADDR = 8'h06;
  // battery_check_config_status fields
  localparam int RESULT_MSB   = 7;
  localparam int RESULT_LSB   = 6;
  localparam int LEVEL_MSB    = 5;
  localparam int LEVEL_LSB    = 3;
  localparam int LOAD_MSB     = 2;
  localparam int LOAD_LSB     = 1;
  localparam int DURATION_BIT = 0;
  localparam logic [5:0] SR6_CFG_RESET = 6'h00;
  localparam logic [1:0] RESULT_IDLE    = 2'b00;
  localparam logic [1:0] RESULT_RUNNING = 2'b01;
  localparam logic [1:0] RESULT_ABOVE   = 2'b10;
  localparam logic [1:0] RESULT_BELOW   = 2'b11;
  // byte counts at chip-select release, and the byte index at which the id is loaded
  localparam logic [2:0] RELEASE_BYTES     = 3'h1;
  localparam logic [2:0] RELEASE_ID_BYTES  = 3'h5;
  localparam logic [2:0] ID_LOAD_INDEX     = 3'h3;
  localparam logic [2:0] WRITE_SR_BYTES    = 3'h3;
  localparam logic [2:0] PROGRAM_MIN_BYTES = 3'h5;
  // hardware reset pattern, first step in the msb
  localparam logic [3:0] RESET_PATTERN = 4'h5;
  // pin synchroniser lanes
  localparam int PIN_CS   = 0;
  localparam int PIN_SCK  = 1;
  localparam int PIN_SI   = 2;
  localparam int PIN_BATT = 3;
  localparam logic [3:0] PIN_RESET = 4'h1;
  // timing
  localparam int CLK_MHZ           = 200;
  localparam int BATT_SHORT_US     = 100;
  localparam int BATT_LONG_US      = 1000;
  localparam int BATT_SHORT_CYCLES = BATT_SHORT_US * CLK_MHZ;
  localparam int BATT_LONG_CYCLES  = BATT_LONG_US * CLK_MHZ;
  localparam int BATT_CNT_W        = 18;
  typedef enum logic [2:0] {
    PWR_ACTIVE  = 3'b001,
    PWR_DEEP    = 3'b010,
    PWR_DEEPEST = 3'b100
  } sfrsb_pwr_type;
endpackage

// ==== sfrsb_spi_host.sv ====
`timescale 1ns/1ps
module sfrsb_spi_host (
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // levels held 8 cycles: the pins pass a slow synchroniser
  task automatic xfer(input logic [63:0] d, input int n, input bit keep, output logic [63:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      o_cs_n <= 1'b0;
      o_si   <= d[i];
      tick(8);
      o_sck <= 1'b1;
      tick(8);
      q = {q[62:0], i_so};
      o_sck <= 1'b0;
    end
    tick(8);
    if (!keep) begin
      release_cs();
    end
  endtask
  task automatic release_cs;
    o_cs_n <= 1'b1;
    o_si   <= ~o_si; // no pull on si: show a changing level
    tick(12);
  endtask
  // one reset step; sck moves only when a scenario asks for it
  task automatic jstep(input logic b, input bit glitch);
    o_cs_n <= 1'b0;
    o_si   <= b;
    tick(8);
    if (glitch) begin
      o_sck <= 1'b1;
      tick(8);
      o_sck <= 1'b0;
      tick(8);
    end
    o_cs_n <= 1'b1;
    tick(8);
  endtask
endmodule

// ==== sfrsb_top.sv ====
`timescale 1ns/1ps
module sfrsb_top
  import sfrsb_pkg::*;
#(
  parameter int unsigned BATT_SHORT_CNT = BATT_SHORT_CYCLES,
  parameter int unsigned BATT_LONG_CNT  = BATT_LONG_CYCLES,
  parameter logic [7:0]  DEVICE_ID      = 8'h5a  // arbitrary value
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sck,
  input  wire logic       i_spi_si,
  input  wire logic       i_batt_below,
  input  wire logic       i_array_done,
  input  wire logic       i_nv_write_busy,
  input  wire logic       i_multi_io_enter,
  output logic            o_spi_so,
  output logic            o_spi_so_oe,
  output logic            o_op_in_progress_flag,
  output logic            o_array_start,
  output logic            o_dev_reset,
  output logic            o_buffer_undefined,
  output logic            o_single_io_mode,
  output logic [2:0]      o_power_state,
  output logic [7:0]      o_battery_check_config_status,
  output logic [2:0]      o_battery_threshold_level,
  output logic [1:0]      o_battery_test_load,
  output logic            o_battery_test_load_en
);

  localparam logic [BATT_CNT_W-1:0] SHORT_LOAD = BATT_CNT_W'(BATT_SHORT_CNT);
  localparam logic [BATT_CNT_W-1:0] LONG_LOAD  = BATT_CNT_W'(BATT_LONG_CNT);
  localparam logic [BATT_CNT_W-1:0] CNT_ONE    = 18'h00001;

  logic [3:0]            s1_reg, s2_reg, s3_reg, pin_reg, pin_prev_reg;
  logic [2:0]            bit_cnt_reg, byte_cnt_reg;
  logic [7:0]            shift_reg, opcode_reg, addr_reg, data_reg, tx_reg;
  logic [1:0]            pat_cnt_reg, result_reg;
  logic [5:0]            cfg_reg;
  logic [BATT_CNT_W-1:0] batt_cnt_reg;
  logic                  sck_seen_reg, reset_pend_reg, busy_reg, load_en_reg;
  logic                  out_en_reg, status_mode_reg, single_reg;
  sfrsb_pwr_type         pwr_reg;

  logic       cs_rise, sck_edge, sck_rise, sck_fall, si, byte_done, awake;
  logic       exec, exec_release, exec_program, exec_batt, exec_term;
  logic       exec_deep, exec_deepest, exec_write, status_start, load_sr, load_id, hw_apply;
  logic [7:0] rx_byte, sr1_value, sr6_value;

  // pins from outside: a change counts once stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_reg       <= PIN_RESET;
      s2_reg       <= PIN_RESET;
      s3_reg       <= PIN_RESET;
      pin_reg      <= PIN_RESET;
      pin_prev_reg <= PIN_RESET;
    end else begin
      s1_reg       <= {i_batt_below, i_spi_si, i_spi_sck, i_spi_cs_n};
      s2_reg       <= s1_reg;
      s3_reg       <= s2_reg;
      pin_reg      <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
      pin_prev_reg <= pin_reg;
    end
  end

  assign cs_rise   = pin_reg[PIN_CS] & ~pin_prev_reg[PIN_CS];
  assign sck_edge  = pin_reg[PIN_SCK] ^ pin_prev_reg[PIN_SCK];
  assign sck_rise  = sck_edge & pin_reg[PIN_SCK] & ~pin_reg[PIN_CS];
  assign sck_fall  = sck_edge & ~pin_reg[PIN_SCK] & ~pin_reg[PIN_CS];
  assign si        = pin_reg[PIN_SI];
  assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);
  assign rx_byte   = {shift_reg[6:0], si};
  assign awake     = (pwr_reg == PWR_ACTIVE);

  // nothing runs when released mid-byte or with no clocks at all
  assign exec         = cs_rise & (bit_cnt_reg == 3'h0) & (byte_cnt_reg != 3'h0);
  assign exec_release = exec & (opcode_reg == OP_RELEASE_PD) &
                        ((byte_cnt_reg == RELEASE_BYTES) | (byte_cnt_reg == RELEASE_ID_BYTES));
  assign exec_program = exec & awake & (opcode_reg == OP_PROGRAM) &
                        (byte_cnt_reg >= PROGRAM_MIN_BYTES) & ~busy_reg;
  assign exec_batt    = exec & awake & (opcode_reg == OP_BATT_CHECK) & ~load_en_reg;
  assign exec_term    = exec & awake & (opcode_reg == OP_TERMINATE);
  assign exec_deep    = exec & awake & (opcode_reg == OP_DEEP_PD);
  assign exec_deepest = exec & awake & (opcode_reg == OP_DEEPEST_PD);
  assign exec_write   = exec & awake & (opcode_reg == OP_WRITE_SR) &
                        (addr_reg == SR6_ADDR) & (byte_cnt_reg == WRITE_SR_BYTES);
  assign status_start = byte_done & awake & (byte_cnt_reg == 3'h0) & (rx_byte == OP_ACTIVE_STATUS);
  assign load_sr      = byte_done & awake & (((byte_cnt_reg == 3'h1) & (opcode_reg == OP_READ_SR)) |
                        ((byte_cnt_reg == 3'h0) & (rx_byte == OP_READ_SR1)));
  assign load_id      = byte_done & (byte_cnt_reg == ID_LOAD_INDEX) & (opcode_reg == OP_RELEASE_PD);
  // a pending reset is held off while a non-volatile write runs
  assign hw_apply     = reset_pend_reg & ~i_nv_write_busy;

  assign sr1_value = {7'h00, busy_reg};
  assign sr6_value = {result_reg, cfg_reg};

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg    <= 8'h00;
      opcode_reg   <= 8'h00;
      addr_reg     <= 8'h00;
      data_reg     <= 8'h00;
    end else if (cs_rise) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      shift_reg   <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done) begin
        // saturates: only the first few byte positions matter here
        if (byte_cnt_reg != 3'h7) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
        if (byte_cnt_reg == 3'h0) begin
          opcode_reg <= rx_byte;
        end
        if (byte_cnt_reg == 3'h1) begin
          addr_reg <= rx_byte;
        end
        if (byte_cnt_reg == 3'h2) begin
          data_reg <= rx_byte;
        end
      end
    end
  end

  // hardware reset pattern detector, cs rises with a quiet clock
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pat_cnt_reg    <= 2'h0;
      sck_seen_reg   <= 1'b0;
      reset_pend_reg <= 1'b0;
    end else begin
      if (hw_apply) begin
        reset_pend_reg <= 1'b0;
      end
      if (sck_edge) begin
        sck_seen_reg <= 1'b1;
        pat_cnt_reg  <= 2'h0;
      end
      if (cs_rise) begin
        sck_seen_reg <= 1'b0;
        if (sck_seen_reg | sck_edge) begin
          pat_cnt_reg <= 2'h0;
        end else if (si == RESET_PATTERN[~pat_cnt_reg]) begin
          if (pat_cnt_reg == 2'h3) begin
            reset_pend_reg <= 1'b1;
            pat_cnt_reg    <= 2'h0;
          end else begin
            pat_cnt_reg <= pat_cnt_reg + 2'h1;
          end
        end else begin
          pat_cnt_reg <= (si == RESET_PATTERN[3]) ? 2'h1 : 2'h0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dev_reset        <= 1'b0;
      o_buffer_undefined <= 1'b0;
    end else begin
      // non-volatile copies live outside; only volatile state is cleared
      o_dev_reset        <= hw_apply;
      o_buffer_undefined <= hw_apply & (pwr_reg == PWR_DEEPEST);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwr_reg <= PWR_ACTIVE;
    end else if (hw_apply) begin
      pwr_reg <= PWR_ACTIVE;
    end else begin
      unique case (pwr_reg)
        PWR_ACTIVE: begin
          if (exec_deep) begin
            pwr_reg <= PWR_DEEP;
          end else if (exec_deepest) begin
            pwr_reg <= PWR_DEEPEST;
          end
        end
        PWR_DEEP, PWR_DEEPEST: begin
          if (exec_release) begin
            pwr_reg <= PWR_ACTIVE;
          end
        end
        default: begin
          pwr_reg <= PWR_ACTIVE;
        end
      endcase
    end
  end

  // the program start wins over a done arriving in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_reg      <= 1'b0;
      o_array_start <= 1'b0;
    end else begin
      o_array_start <= exec_program;
      if (hw_apply) begin
        busy_reg <= 1'b0;
      end else if (exec_program) begin
        busy_reg <= 1'b1;
      end else if (i_array_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      single_reg <= 1'b1;
    end else if (hw_apply) begin
      single_reg <= 1'b1;
    end else if (i_multi_io_enter) begin
      single_reg <= 1'b0;
    end
  end

  // battery check sequencer; completion is written last so it wins
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_reg      <= SR6_CFG_RESET;
      result_reg   <= RESULT_IDLE;
      load_en_reg  <= 1'b0;
      batt_cnt_reg <= '0;
    end else if (hw_apply) begin
      cfg_reg      <= SR6_CFG_RESET;
      result_reg   <= RESULT_IDLE;
      load_en_reg  <= 1'b0;
      batt_cnt_reg <= '0;
    end else begin
      if (exec_write) begin
        cfg_reg <= data_reg[LEVEL_MSB:0];
      end
      if (exec_term) begin
        result_reg  <= RESULT_IDLE;
        load_en_reg <= 1'b0;
      end
      if (exec_batt) begin
        result_reg   <= RESULT_RUNNING;
        load_en_reg  <= 1'b1;
        batt_cnt_reg <= cfg_reg[DURATION_BIT] ? LONG_LOAD : SHORT_LOAD;
      end else if (load_en_reg) begin
        batt_cnt_reg <= batt_cnt_reg - CNT_ONE;
        if (batt_cnt_reg == CNT_ONE) begin
          // comparator reports below only under the selected level
          result_reg  <= pin_reg[PIN_BATT] ? RESULT_BELOW : RESULT_ABOVE;
          load_en_reg <= 1'b0;
        end
      end
    end
  end

  // serial output: status mode mirrors busy or the battery load every cycle, reads shift on sck fall
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_reg          <= 8'h00;
      out_en_reg      <= 1'b0;
      status_mode_reg <= 1'b0;
      o_spi_so        <= 1'b0;
      o_spi_so_oe     <= 1'b0;
    end else if (cs_rise | hw_apply) begin
      out_en_reg      <= 1'b0;
      status_mode_reg <= 1'b0;
      o_spi_so        <= 1'b0;
      o_spi_so_oe     <= 1'b0;
    end else begin
      if (status_start) begin
        status_mode_reg <= 1'b1;
      end
      if (load_sr) begin
        tx_reg     <= ((opcode_reg == OP_READ_SR) && (rx_byte == SR6_ADDR)) ? sr6_value : sr1_value;
        out_en_reg <= 1'b1;
      end else if (load_id) begin
        tx_reg     <= DEVICE_ID;
        out_en_reg <= 1'b1;
      end else if (sck_fall & out_en_reg) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (status_mode_reg) begin
        o_spi_so    <= busy_reg | load_en_reg;
        o_spi_so_oe <= 1'b1;
      end else if (sck_fall & out_en_reg) begin
        o_spi_so    <= tx_reg[7];
        o_spi_so_oe <= 1'b1;
      end
    end
  end

  assign o_op_in_progress_flag         = busy_reg;
  assign o_single_io_mode              = single_reg;
  assign o_power_state                 = pwr_reg;
  assign o_battery_check_config_status = sr6_value;
  assign o_battery_threshold_level     = cfg_reg[LEVEL_MSB:LEVEL_LSB];
  assign o_battery_test_load           = cfg_reg[LOAD_MSB:LOAD_LSB];
  assign o_battery_test_load_en        = load_en_reg;

endmodule
